// >>> tcc_defines.svh
// offsets, field positions, reset values and fixed codes of the test capability block
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH
// capability structure offsets (configuration space, byte addresses)
`define TCC_OFF_HDR_ONE 12'h004
`define TCC_OFF_HDR_TWO 12'h008
`define TCC_OFF_LOCK 12'h00A
`define TCC_OFF_FLAGS 12'h00C
`define TCC_OFF_CACHE 12'h010
`define TCC_OFF_BASE_LO 12'h014
`define TCC_OFF_BASE_HI 12'h018
// header fields
`define TCC_HDR_REV 4'h0
`define TCC_HDR_LEN 12'h022
// vendor and structure identifiers: arbitrary neutral values
`define TCC_VENDOR_CODE 16'h1234
`define TCC_STRUCT_ID 16'h0055
// base low fixed fields
`define TCC_SPACE_MEM 1'b0
`define TCC_BASE_W32 2'b00
`define TCC_BASE_W64 2'b10
// cache size units
`define TCC_UNIT_BYTES 2'b00
`define TCC_UNIT_KB 2'b01
`define TCC_UNIT_MB 2'b10
// test region offsets
`define TCC_RG_START 8'h00
`define TCC_RG_WBACK 8'h08
`define TCC_RG_SIZE 8'h10
`define TCC_RESET_64 64'h0000000000000000
`endif

// >>> tcc_pkg.sv
// types shared by the test capability register block
package tcc_pkg;
   typedef enum logic [1:0] {TCC_CFG_IDLE, TCC_CFG_LOCKED} tcc_lock_e;
   typedef logic [63:0] tcc_addr_t;
endpackage

// >>> tcc_region_regs.sv
// memory-mapped test setup registers: start and write-back pointers
`timescale 1ns/1ps
`include "tcc_defines.svh"
module tcc_region_regs
   import tcc_pkg::*;
(
   input wire logic sys_clk, // device clock
   input wire logic rst_n, // sync reset, low active
   input wire logic clk_en, // freezes state while low
   input wire logic wr_en, // region write strobe
   input wire logic locked, // writes blocked
   input wire logic [7:0] wr_off, // region offset of write
   input wire logic [7:0] wr_be, // byte enables
   input wire logic [63:0] wr_data, // write data
   output tcc_addr_t start_ptr, // set start pointer
   output tcc_addr_t wback_ptr // result copy pointer
);
   tcc_addr_t start_ff;
   tcc_addr_t wback_ff;
   logic do_start;
   logic do_wback;

   // merge byte lanes into an old word
   function automatic tcc_addr_t merge(tcc_addr_t old, tcc_addr_t nw, logic [7:0] be);
      tcc_addr_t r;
      r = old;
      for (int i = 0; i < 8; i++) begin
         if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
      end
      return r;
   endfunction

   // decode, lock gate
   assign do_start = wr_en && !locked && (wr_off == `TCC_RG_START);
   assign do_wback = wr_en && !locked && (wr_off == `TCC_RG_WBACK);

   // pointer registers, all zero after reset
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         start_ff <= `TCC_RESET_64;
         wback_ff <= `TCC_RESET_64;
      end else if (clk_en) begin
         if (do_start) start_ff <= merge(start_ff, wr_data, wr_be);
         if (do_wback) wback_ff <= merge(wback_ff, wr_data, wr_be);
      end
   end

   assign start_ptr = start_ff;
   assign wback_ptr = wback_ff;

   chk_locked_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
      clk_en && $past(locked) && $past(clk_en) |-> $stable(start_ff) && $stable(wback_ff))
      else $error("pointer changed while locked");
endmodule

// >>> tcc_cap_regs.sv
// test capability structure and test setup region register block
`timescale 1ns/1ps
`include "tcc_defines.svh"
// Behaviour
// - Header one reads vendor code in 15:0, revision zero in 19:16 and length 0x22 in 31:20.
// - Header two at offset eight reads the fixed structure identifier in 15:0.
// - Writing one to lock bit zero locks the setup registers; bits 15:1 read zero.
// - Feature bits 0..3 show self-check and algorithm 1a, 1b and 2 support.
// - Feature bits 4..18 show which coherent request opcodes the device can issue.
// - Bit 19 shows stray completion support, bit 20 dropped read support, 23:21 zero.
// - Feature bits 31:24 give the setup region size in bytes.
// - Cache word gives capacity in 13:0 and its unit in 15:14.
// - Base low bit 0 reads zero for memory space and bit 3 reads zero.
// - Base low bits 2:1 give the base width code, 00 or 10.
// - Base low 31:4 and base high hold address bits 31:4 and 63:32.
// - Setup registers decode relative to the programmed base and reset to zero.
// - Region offset zero holds the 64-bit set start pointer.
// - Region offset eight holds the write-back pointer, used only without self-check.
module tcc_cap_regs
   import tcc_pkg::*;
#(
   parameter logic [3:0] ALGO_SUPPORT = 4'h0, // self-check, 1a, 1b, 2
   parameter logic [14:0] OPCODE_SUPPORT = 15'h0000, // requester opcodes
   parameter logic STRAY_CPL = 1'b0, // stray completion support
   parameter logic DROP_RD = 1'b0, // dropped read support
   parameter logic [13:0] CACHE_CAP = 14'h0000, // cache capacity
   parameter logic [1:0] CACHE_UNIT = `TCC_UNIT_KB, // capacity unit
   parameter logic [1:0] BASE_WIDTH = `TCC_BASE_W64 // base width code
)(
   input wire logic sys_clk, // device clock
   input wire logic rst_n, // sync reset, low active
   input wire logic clk_en, // freezes state while low
   input wire logic cfg_wr, // config write strobe
   input wire logic cfg_rd, // config read strobe
   input wire logic [11:0] cfg_addr, // config byte address, word aligned
   input wire logic [3:0] cfg_be, // config byte enables
   input wire logic [31:0] cfg_wdata, // config write data
   output logic [31:0] cfg_rdata, // config read data
   output logic cfg_rvalid, // config read data valid
   input wire logic mem_wr, // memory write strobe
   input wire logic mem_rd, // memory read strobe
   input wire logic [63:0] mem_addr, // memory byte address
   input wire logic [7:0] mem_be, // memory byte enables
   input wire logic [63:0] mem_wdata, // memory write data
   output logic [63:0] mem_rdata, // memory read data
   output logic mem_rvalid, // memory read hit valid
   output logic [63:0] set_start_pointer, // start pointer to the engine
   output logic [63:0] result_copy_pointer, // write-back pointer to the engine
   output logic wback_in_use, // write-back pointer active
   output logic config_lock_bit // lock state
);
   // ***************************************************
   // configuration structure
   // ***************************************************
   tcc_lock_e lock_ff;
   logic [27:0] base_lo_ff;
   logic [31:0] base_hi_ff;
   logic self_check_en;
   logic [31:0] cfg_rdata_ff;
   logic cfg_rvalid_ff;
   logic [63:0] mem_rdata_ff;
   logic mem_rvalid_ff;
   logic [63:0] start_ptr_ff;
   logic [63:0] wback_ptr_ff;
   logic wback_use_ff;
   logic config_lock_ff;

   logic [31:0] hdr_one;
   logic [31:0] hdr_two_lock;
   logic [31:0] feature_word;
   logic [31:0] cache_word;
   logic [31:0] base_lo_word;
   logic self_check_support;
   logic algo_one_a_support;
   logic algo_one_b_support;
   logic algo_two_support;
   logic stray_completion_support;
   logic dropped_read_support;
   logic [7:0] setup_region_size;
   logic [13:0] cache_capacity;
   logic [1:0] cache_capacity_units;
   logic space_kind_bit;
   logic locked;
   logic lock_set;
   logic [63:0] region_base;
   logic in_region;
   logic [7:0] region_off;
   logic [31:0] cfg_sel;
   tcc_addr_t start_ptr;
   tcc_addr_t wback_ptr;
   logic [63:0] mem_sel;
   logic [31:0] base_lo_merged;

   // merge a 32-bit config word under byte enables
   function automatic logic [31:0] merge32(logic [31:0] old, logic [31:0] nw, logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
      end
      return r;
   endfunction

   // capability fields
   assign self_check_support = ALGO_SUPPORT[0];
   assign algo_one_a_support = ALGO_SUPPORT[1];
   assign algo_one_b_support = ALGO_SUPPORT[2];
   assign algo_two_support = ALGO_SUPPORT[3];
   assign stray_completion_support = STRAY_CPL;
   assign dropped_read_support = DROP_RD;
   assign setup_region_size = `TCC_RG_SIZE;
   assign cache_capacity = CACHE_CAP;
   assign cache_capacity_units = CACHE_UNIT;
   assign space_kind_bit = `TCC_SPACE_MEM;

   // read words of the structure
   assign hdr_one = {`TCC_HDR_LEN, `TCC_HDR_REV, `TCC_VENDOR_CODE};
   assign locked = (lock_ff == TCC_CFG_LOCKED);
   assign hdr_two_lock = {15'h0000, locked, `TCC_STRUCT_ID};
   assign feature_word = {setup_region_size, 3'h0, dropped_read_support,
      stray_completion_support, OPCODE_SUPPORT, algo_two_support,
      algo_one_b_support, algo_one_a_support, self_check_support};
   assign cache_word = {16'h0000, cache_capacity_units, cache_capacity};
   assign base_lo_word = {base_lo_ff, 1'b0, BASE_WIDTH, space_kind_bit};

   // config read select; unmapped reads zero
   assign cfg_sel = (cfg_addr == `TCC_OFF_HDR_ONE) ? hdr_one :
                    (cfg_addr == `TCC_OFF_HDR_TWO) ? hdr_two_lock :
                    (cfg_addr == `TCC_OFF_FLAGS) ? feature_word :
                    (cfg_addr == `TCC_OFF_CACHE) ? cache_word :
                    (cfg_addr == `TCC_OFF_BASE_LO) ? base_lo_word :
                    (cfg_addr == `TCC_OFF_BASE_HI) ? base_hi_ff : 32'h00000000;

   // lock lives in byte lane 2 of the dword at offset 08h
   assign lock_set = cfg_wr && (cfg_addr == `TCC_OFF_HDR_TWO) && cfg_be[2] && cfg_wdata[16];

   // lock state: write once, held until reset
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         lock_ff <= TCC_CFG_IDLE;
      end else if (clk_en) begin
         case (lock_ff)
            TCC_CFG_IDLE: begin
               if (lock_set) lock_ff <= TCC_CFG_LOCKED;
            end
            TCC_CFG_LOCKED: lock_ff <= TCC_CFG_LOCKED;
            default: lock_ff <= TCC_CFG_IDLE;
         endcase
      end
   end

   // low base word as it would read after the write; fixed low bits drop out below
   assign base_lo_merged = merge32(base_lo_word, cfg_wdata, cfg_be);

   // base address registers
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         base_lo_ff <= 28'h0000000;
         base_hi_ff <= 32'h00000000;
      end else if (clk_en && cfg_wr) begin
         if (cfg_addr == `TCC_OFF_BASE_LO) base_lo_ff <= base_lo_merged[31:4];
         if (cfg_addr == `TCC_OFF_BASE_HI) base_hi_ff <= merge32(base_hi_ff, cfg_wdata, cfg_be);
      end
   end

   // config read answer, one cycle after the strobe
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cfg_rdata_ff <= 32'h00000000;
         cfg_rvalid_ff <= 1'b0;
      end else if (clk_en) begin
         cfg_rvalid_ff <= cfg_rd;
         if (cfg_rd) cfg_rdata_ff <= cfg_sel;
      end
   end

   // ***************************************************
   // memory-mapped setup region
   // ***************************************************
   // 32-bit base code ignores the high word
   assign region_base = (BASE_WIDTH == `TCC_BASE_W32) ? {32'h00000000, base_lo_ff, 4'h0} :
                        {base_hi_ff, base_lo_ff, 4'h0};
   assign in_region = (mem_addr >= region_base) &&
                      ((mem_addr - region_base) < 64'(`TCC_RG_SIZE));
   assign region_off = 8'(mem_addr - region_base);

   tcc_region_regs u_region (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .wr_en(mem_wr && in_region),
      .locked(locked),
      .wr_off(region_off),
      .wr_be(mem_be),
      .wr_data(mem_wdata),
      .start_ptr(start_ptr),
      .wback_ptr(wback_ptr)
   );

   assign mem_sel = (region_off == `TCC_RG_START) ? start_ptr :
                    (region_off == `TCC_RG_WBACK) ? wback_ptr : 64'h0000000000000000;

   // self-check enable lives outside this block; tie to support for now
   assign self_check_en = self_check_support;

   // region read answer and pointer outputs
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         mem_rdata_ff <= `TCC_RESET_64;
         mem_rvalid_ff <= 1'b0;
         start_ptr_ff <= `TCC_RESET_64;
         wback_ptr_ff <= `TCC_RESET_64;
         wback_use_ff <= 1'b0;
         config_lock_ff <= 1'b0;
      end else if (clk_en) begin
         mem_rvalid_ff <= mem_rd && in_region;
         if (mem_rd && in_region) mem_rdata_ff <= mem_sel;
         start_ptr_ff <= start_ptr;
         wback_ptr_ff <= wback_ptr;
         wback_use_ff <= !self_check_en;
         config_lock_ff <= locked;
      end
   end

   assign cfg_rdata = cfg_rdata_ff;
   assign cfg_rvalid = cfg_rvalid_ff;
   assign mem_rdata = mem_rdata_ff;
   assign mem_rvalid = mem_rvalid_ff;
   assign set_start_pointer = start_ptr_ff;
   assign result_copy_pointer = wback_ptr_ff;
   assign wback_in_use = wback_use_ff;
   assign config_lock_bit = config_lock_ff;

   // ***************************************************
   // checks
   // ***************************************************
   chk_header_one_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
      clk_en && cfg_rd && cfg_addr == `TCC_OFF_HDR_ONE |=> cfg_rvalid && cfg_rdata[31:16] == 16'h0220)
      else $error("header one wrong");
   chk_struct_id: assert property (@(posedge sys_clk) disable iff (!rst_n)
      clk_en && cfg_rd && cfg_addr == `TCC_OFF_HDR_TWO |=> cfg_rdata[15:0] == `TCC_STRUCT_ID)
      else $error("structure id wrong");
   sequence lock_write_s;
      clk_en && lock_set;
   endsequence
   chk_lock_sets: assert property (@(posedge sys_clk) disable iff (!rst_n)
      lock_write_s ##1 clk_en |=> config_lock_bit)
      else $error("lock did not set");
   chk_lock_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
      locked |=> locked)
      else $error("lock cleared before reset");
   chk_feature_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
      clk_en && cfg_rd && cfg_addr == `TCC_OFF_FLAGS |=> cfg_rdata[18:0] == {OPCODE_SUPPORT,
      ALGO_SUPPORT} && cfg_rdata[23:21] == 3'h0 && cfg_rdata[31:24] == `TCC_RG_SIZE)
      else $error("feature word wrong");
   chk_base_fixed: assert property (@(posedge sys_clk) disable iff (!rst_n)
      clk_en && cfg_rd && cfg_addr == `TCC_OFF_BASE_LO |=> cfg_rdata[3:0] == {1'b0, BASE_WIDTH, 1'b0})
      else $error("base low fixed bits wrong");
   chk_cache_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
      clk_en && cfg_rd && cfg_addr == `TCC_OFF_CACHE |=> cfg_rdata[15:0] == {CACHE_UNIT, CACHE_CAP})
      else $error("cache word wrong");
   chk_start_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
      clk_en && mem_wr && in_region && !locked && region_off == `TCC_RG_START && mem_be == 8'hFF
      ##1 clk_en |=> set_start_pointer == $past(mem_wdata, 2))
      else $error("start pointer not written");
   sequence wback_write_s;
      clk_en && mem_wr && in_region && !locked &&
      region_off == `TCC_RG_WBACK && mem_be == 8'hFF;
   endsequence
   chk_wback_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
      wback_write_s ##1 clk_en |=> result_copy_pointer == $past(mem_wdata, 2))
      else $error("write-back pointer not written");
   chk_wback_use: assert property (@(posedge sys_clk) disable iff (!rst_n)
      clk_en |=> wback_in_use == !self_check_support)
      else $error("write-back use flag wrong");
   chk_lock_output: assert property (@(posedge sys_clk) disable iff (!rst_n)
      clk_en |=> config_lock_bit == $past(locked))
      else $error("lock output does not follow lock state");

   // ***************************************************
   // read answer timing
   // ***************************************************
   // a read taken at one edge is answered at the next, and only then
   sequence cfg_take_s;
      clk_en && cfg_rd;
   endsequence
   sequence region_hit_s;
      clk_en && mem_rd && in_region;
   endsequence
   sequence region_miss_s;
      clk_en && mem_rd && !in_region;
   endsequence
   chk_cfg_answer: assert property (@(posedge sys_clk) disable iff (!rst_n)
      cfg_take_s |=> cfg_rvalid)
      else $error("config read not answered");
   chk_cfg_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
      clk_en && !cfg_rd |=> !cfg_rvalid)
      else $error("stray config answer");
   chk_region_hit: assert property (@(posedge sys_clk) disable iff (!rst_n)
      region_hit_s |=> mem_rvalid)
      else $error("region read not answered");
   chk_region_miss: assert property (@(posedge sys_clk) disable iff (!rst_n)
      region_miss_s |=> !mem_rvalid)
      else $error("region miss answered");
   chk_lock_field: assert property (@(posedge sys_clk) disable iff (!rst_n)
      cfg_take_s ##0 cfg_addr == `TCC_OFF_HDR_TWO
      |=> cfg_rdata[31:16] == {15'h0000, $past(locked)})
      else $error("lock field wrong");
   chk_base_high_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
      cfg_take_s ##0 cfg_addr == `TCC_OFF_BASE_HI
      |=> cfg_rdata == $past(base_hi_ff))
      else $error("base high read wrong");
endmodule

// >>> tcc_cap_regs_tb.sv
// self-checking testbench for the test capability register block
`timescale 1ns/1ps
`include "tcc_defines.svh"
module tcc_cap_regs_tb;
   // ****************************************
   // parameters, signals and device under test
   // ****************************************
   localparam logic [3:0] ALGO = 4'hE;
   localparam logic [14:0] OPC = 15'h5A3C;
   localparam logic [13:0] CCAP = 14'h1ABC;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic clk_en = 1'b1;
   logic cfg_wr = 1'b0;
   logic cfg_rd = 1'b0;
   logic [11:0] cfg_addr = 12'h000;
   logic [3:0] cfg_be = 4'h0;
   logic [31:0] cfg_wdata = 32'h0;
   logic [31:0] cfg_rdata;
   logic cfg_rvalid;
   logic mem_wr = 1'b0;
   logic mem_rd = 1'b0;
   logic [63:0] mem_addr = 64'h0;
   logic [7:0] mem_be = 8'h00;
   logic [63:0] mem_wdata = 64'h0;
   logic [63:0] mem_rdata;
   logic mem_rvalid;
   logic [63:0] set_start_pointer;
   logic [63:0] result_copy_pointer;
   logic wback_in_use;
   logic config_lock_bit;
   logic [63:0] cfg_q[$];
   logic [63:0] mem_q[$];
   logic [63:0] base, s, w, w2;
   logic [31:0] lo, hi;
   int error_cnt = 0;
   int checks_done = 0;

   tcc_cap_regs #(.ALGO_SUPPORT(ALGO), .OPCODE_SUPPORT(OPC), .STRAY_CPL(1'b1),
      .DROP_RD(1'b0), .CACHE_CAP(CCAP), .CACHE_UNIT(`TCC_UNIT_MB),
      .BASE_WIDTH(`TCC_BASE_W64)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
      .clk_en(clk_en), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
      .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
      .cfg_rvalid(cfg_rvalid), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_addr(mem_addr),
      .mem_be(mem_be), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
      .mem_rvalid(mem_rvalid), .set_start_pointer(set_start_pointer),
      .result_copy_pointer(result_copy_pointer), .wback_in_use(wback_in_use),
      .config_lock_bit(config_lock_bit));

   // clock at 50 ns period
   always #25 sys_clk = ~sys_clk;

   // ****************************************
   // checking, reporting and bus tasks
   // ****************************************
   task automatic check(input logic [63:0] got, input logic [63:0] exp, input string msg);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
      end
   endtask

   task automatic test_done();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // reset held for four cycles, then two enabled edges to settle
   task automatic do_reset();
      @(posedge sys_clk);
      #1 rst_n = 1'b0;
      repeat (4) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask

   // one config request held across its taking edge
   task automatic drive_cfg(input logic wr, input logic [11:0] a, input logic [3:0] be,
                            input logic [31:0] d);
      @(posedge sys_clk);
      #1 cfg_wr = wr;
      cfg_rd = ~wr;
      cfg_addr = a;
      cfg_be = be;
      cfg_wdata = d;
      @(posedge sys_clk);
      #1 cfg_wr = 1'b0;
      cfg_rd = 1'b0;
   endtask

   task automatic drive_mem(input logic wr, input logic [63:0] a, input logic [7:0] be,
                            input logic [63:0] d);
      @(posedge sys_clk);
      #1 mem_wr = wr;
      mem_rd = ~wr;
      mem_addr = a;
      mem_be = be;
      mem_wdata = d;
      @(posedge sys_clk);
      #1 mem_wr = 1'b0;
      mem_rd = 1'b0;
   endtask

   // reads note the expected word before the request goes out
   task automatic cfg_read(input logic [11:0] a, input logic [31:0] exp);
      cfg_q.push_back({32'h0, exp});
      drive_cfg(1'b0, a, 4'hF, 32'h0);
   endtask

   task automatic mem_read(input logic [63:0] a, input logic [63:0] exp);
      mem_q.push_back(exp);
      drive_mem(1'b0, a, 8'hFF, 64'h0);
   endtask

   // watcher: every read answer takes the oldest note; an answer with no note is an error
   always @(posedge sys_clk) begin
      if (cfg_rvalid === 1'b1) begin
         if (cfg_q.size() == 0) check(1'b1, 1'b0, "config answer without request");
         else check({32'h0, cfg_rdata}, cfg_q.pop_front(), "config read");
      end
      if (mem_rvalid === 1'b1) begin
         if (mem_q.size() == 0) check(1'b1, 1'b0, "region answer on a miss");
         else check(mem_rdata, mem_q.pop_front(), "region read");
      end
   end

   // hang guard
   initial begin
      repeat (4000) @(posedge sys_clk);
      check(1'b1, 1'b0, "run limit reached");
      test_done();
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      void'($urandom(74));
      do_reset();
      check(set_start_pointer, 64'h0, "start pointer after reset");
      check(config_lock_bit, 1'b0, "lock after reset");
      check(wback_in_use, !ALGO[0], "write-back use");
      cfg_read(`TCC_OFF_HDR_ONE, {`TCC_HDR_LEN, `TCC_HDR_REV, `TCC_VENDOR_CODE});
      cfg_read(`TCC_OFF_HDR_TWO, {16'h0000, `TCC_STRUCT_ID});
      cfg_read(`TCC_OFF_FLAGS, {`TCC_RG_SIZE, 3'b000, 1'b0, 1'b1, OPC, ALGO});
      cfg_read(`TCC_OFF_CACHE, {16'h0000, `TCC_UNIT_MB, CCAP});
      cfg_read(12'h01C, 32'h0);
      // read-only words ignore writes
      drive_cfg(1'b1, `TCC_OFF_FLAGS, 4'hF, 32'hFFFFFFFF);
      cfg_read(`TCC_OFF_FLAGS, {`TCC_RG_SIZE, 3'b000, 1'b0, 1'b1, OPC, ALGO});
      // fixed low bits of the base survive an all-ones write
      drive_cfg(1'b1, `TCC_OFF_BASE_LO, 4'hF, 32'hFFFFFFFF);
      cfg_read(`TCC_OFF_BASE_LO, {28'hFFFFFFF, 1'b0, `TCC_BASE_W64, `TCC_SPACE_MEM});
      lo = $urandom;
      hi = $urandom;
      drive_cfg(1'b1, `TCC_OFF_BASE_LO, 4'hF, lo);
      drive_cfg(1'b1, `TCC_OFF_BASE_HI, 4'hF, hi);
      cfg_read(`TCC_OFF_BASE_LO, {lo[31:4], 1'b0, `TCC_BASE_W64, 1'b0});
      cfg_read(`TCC_OFF_BASE_HI, hi);
      base = {hi, lo[31:4], 4'h0};
      mem_read(base, 64'h0);
      mem_read(base + 64'h8, 64'h0);
      // start pointer: full write, then port and readback
      s = {$urandom, $urandom};
      drive_mem(1'b1, base, 8'hFF, s);
      @(posedge sys_clk);
      #1 check(set_start_pointer, s, "start pointer port");
      mem_read(base, s);
      // write-back pointer aimed at host memory, then a partial byte-enable update
      w = {$urandom, $urandom};
      w2 = {$urandom, $urandom};
      drive_mem(1'b1, base + 64'h8, 8'hFF, w);
      drive_mem(1'b1, base + 64'h8, 8'h0F, w2);
      mem_read(base + 64'h8, {w[63:32], w2[31:0]});
      check(result_copy_pointer, {w[63:32], w2[31:0]}, "write-back port");
      // a read just past the region must not answer
      drive_mem(1'b0, base + 64'h10, 8'hFF, 64'h0);
      // a write with the clock enable low is not taken
      clk_en = 1'b0;
      drive_mem(1'b1, base, 8'hFF, ~s);
      clk_en = 1'b1;
      mem_read(base, s);
      // lock, then region writes and lock clears are ignored
      drive_cfg(1'b1, `TCC_OFF_HDR_TWO, 4'b0100, 32'h00010000);
      @(posedge sys_clk);
      #1 check(config_lock_bit, 1'b1, "lock port");
      cfg_read(`TCC_OFF_HDR_TWO, {15'h0, 1'b1, `TCC_STRUCT_ID});
      drive_mem(1'b1, base, 8'hFF, ~s);
      mem_read(base, s);
      drive_cfg(1'b1, `TCC_OFF_HDR_TWO, 4'b0100, 32'h0);
      cfg_read(`TCC_OFF_HDR_TWO, {15'h0, 1'b1, `TCC_STRUCT_ID});
      // a second reset releases the lock and clears the setup registers
      do_reset();
      check(config_lock_bit, 1'b0, "lock after second reset");
      check(set_start_pointer, 64'h0, "start pointer after second reset");
      check(result_copy_pointer, 64'h0, "write-back after second reset");
      for (int i = 0; i < 20 && (cfg_q.size() + mem_q.size()) > 0; i++) @(posedge sys_clk);
      if ((cfg_q.size() + mem_q.size()) > 0) check(1'b1, 1'b0, "reads left unanswered");
      test_done();
   end
endmodule
